/* File: design/async_serial_transmitter_frame.sv */
// Purpose: Asynchronous serial transmitter with frame format, break and idle
//          generation, flags, interrupt and a compact receiver for data and break.
// Assumes: Wishbone master of the classic single-cycle kind; serial input synchronous.
// Notes:   Registers answer one cycle after the request and act on the ack edge.
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module async_serial_transmitter_frame
  import serial_tx_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic                   wb_ack_o,
  output logic [31:0]            wb_dat_o,
  input  wire logic              global_mask_i,
  input  wire logic              serial_rx_in_i,
  output logic                   tx_o,
  output logic                   tx_oe_n_o,
  output logic                   irq_o
);

  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 8");
  end

  logic [7:0]  ctrl_one_r;
  logic [7:0]  ctrl_two_r;
  logic [7:0]  baud_r;
  logic [7:0]  tx_fine_r;
  logic [7:0]  rx_fine_r;
  logic        tx_buffer_empty_r;
  logic        tx_complete_r;
  logic        rx_full_r;
  logic        rx_break_r;
  logic        rx_ninth_bit_r;
  logic [7:0]  rx_data_r;
  logic        stat_seen_r;
  logic [7:0]  buf_r;
  logic        buf_full_r;
  logic        idle_pend_r;
  logic        brk_tail_r;
  logic        te_d_r;
  tx_state_t   tx_state_r;
  logic [10:0] tx_shift_r;
  logic [3:0]  tx_left_r;
  logic [3:0]  tx_sub_r;
  logic [19:0] tx_div_r;
  rx_state_t   rx_state_r;
  logic [3:0]  rx_sub_r;
  logic [3:0]  rx_left_r;
  logic [8:0]  rx_shift_r;
  logic [19:0] rx_div_r;
  logic        ack_r;
  logic [7:0]  rd_nxt;

  wire logic        word_len     = ctrl_one_r[C1_WORD_LEN];
  wire logic        tx_ninth_bit = ctrl_one_r[C1_TX_NINTH];
  wire logic        tx_enable    = ctrl_two_r[C2_TX_EN];
  wire logic        rx_enable    = ctrl_two_r[C2_RX_EN];
  wire logic        send_break   = ctrl_two_r[C2_BREAK];
  wire logic [3:0]  frame_len    = word_len ? FRAME_LEN_9 : FRAME_LEN_8;
  wire logic [7:0]  adr8         = 8'(wb_adr_i);
  wire logic        acc          = wb_cyc_i & wb_stb_i & ack_r;
  wire logic        wr_lane      = acc & wb_we_i & wb_sel_i[0];
  wire logic        wr_data      = wr_lane & (adr8 == OFS_DATA);
  wire logic        rd_data      = acc & ~wb_we_i & (adr8 == OFS_DATA);
  wire logic        acc_status   = acc & (adr8 == OFS_STATUS);
  wire logic        seq_clear    = wr_data & stat_seen_r;
  wire logic        rd_clear     = rd_data & stat_seen_r;
  wire logic        te_rise      = tx_enable & ~te_d_r;

  // Separate generators, each divided by prescaler, power of two and fine value.
  wire logic [19:0] tx_lim = baud_div(baud_r[7:6], baud_r[5:3], tx_fine_r);
  wire logic [19:0] rx_lim = baud_div(baud_r[7:6], baud_r[2:0], rx_fine_r);
  wire logic        tx_tick = (tx_div_r >= tx_lim - 20'h00001);
  wire logic        rx_tick = (rx_div_r >= rx_lim - 20'h00001);

  wire logic tx_bit_end   = (tx_state_r == TX_FRAME) & tx_tick & (tx_sub_r == SUB_LAST);
  wire logic tx_frame_end = tx_bit_end & (tx_left_r == 4'h1);
  wire logic tx_decide    = (tx_state_r == TX_IDLE) | tx_frame_end;

  logic tx_load_idle;
  logic tx_load_break;
  logic tx_load_tail;
  logic tx_load_data;

  always_comb begin
    tx_load_idle  = 1'b0;
    tx_load_break = 1'b0;
    tx_load_tail  = 1'b0;
    tx_load_data  = 1'b0;
    // The enable's rising cycle only arms the idle frame, so stale data never jumps ahead.
    if (tx_decide && tx_enable && !te_rise) begin
      if (idle_pend_r) begin
        tx_load_idle = 1'b1;
      end else if (send_break) begin
        tx_load_break = 1'b1;
      end else if (brk_tail_r) begin
        tx_load_tail = 1'b1;
      end else if (buf_full_r) begin
        tx_load_data = 1'b1;
      end
    end
  end

  wire logic tx_load = tx_load_idle | tx_load_break | tx_load_tail | tx_load_data;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_r    <= wb_cyc_i & wb_stb_i & ~ack_r;
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~ack_r;
      wb_dat_o <= {24'h00_0000, rd_nxt};
    end
  end

  // Unmapped addresses are acknowledged and read as zero.
  always_comb begin
    case (adr8)
      OFS_STATUS:   rd_nxt = {tx_buffer_empty_r, tx_complete_r, rx_full_r, rx_break_r, 4'h0};
      OFS_DATA:     rd_nxt = rx_data_r;
      OFS_CTRL_ONE: rd_nxt = {rx_ninth_bit_r, ctrl_one_r[6:0]};
      OFS_CTRL_TWO: rd_nxt = ctrl_two_r;
      OFS_BAUD:     rd_nxt = baud_r;
      OFS_TX_FINE:  rd_nxt = tx_fine_r;
      OFS_RX_FINE:  rd_nxt = rx_fine_r;
      default:      rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_one_r <= CTRL_ONE_RST;
      ctrl_two_r <= CTRL_TWO_RST;
      baud_r     <= BAUD_RST;
      tx_fine_r  <= FINE_RST;
      rx_fine_r  <= FINE_RST;
    end else if (wr_lane) begin
      case (adr8)
        OFS_CTRL_ONE: ctrl_one_r <= {1'b0, wb_dat_i[6:0]};
        OFS_CTRL_TWO: ctrl_two_r <= wb_dat_i[7:0];
        OFS_BAUD:     baud_r     <= wb_dat_i[7:0];
        OFS_TX_FINE:  tx_fine_r  <= wb_dat_i[7:0];
        OFS_RX_FINE:  rx_fine_r  <= wb_dat_i[7:0];
        default:      ctrl_one_r <= ctrl_one_r;
      endcase
    end
  end

  // A status access arms the clearing sequence; the next data access ends it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_seen_r <= 1'b0;
    end else if (acc_status) begin
      stat_seen_r <= 1'b1;
    end else if (wr_data || rd_data) begin
      stat_seen_r <= 1'b0;
    end
  end

  // Set wins over the software clear in every flag below.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buffer_empty_r <= 1'b1;
      tx_complete_r     <= 1'b1;
    end else begin
      if (tx_load_data) begin
        tx_buffer_empty_r <= 1'b1;
      end else if (seq_clear) begin
        tx_buffer_empty_r <= 1'b0;
      end
      if (tx_frame_end && !tx_load) begin
        tx_complete_r <= 1'b1;
      end else if (seq_clear) begin
        tx_complete_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_r       <= 8'h00;
      buf_full_r  <= 1'b0;
      idle_pend_r <= 1'b0;
      brk_tail_r  <= 1'b0;
      te_d_r      <= 1'b0;
    end else begin
      te_d_r <= tx_enable;
      if (te_rise) begin
        buf_full_r  <= 1'b0;
        idle_pend_r <= 1'b1;
      end else begin
        if (tx_load_data) begin
          buf_full_r <= 1'b0;
        end
        if (tx_load_idle) begin
          idle_pend_r <= 1'b0;
        end
      end
      if (wr_data) begin
        buf_r      <= wb_dat_i[7:0];
        buf_full_r <= 1'b1;
      end
      if (tx_load_break) begin
        brk_tail_r <= 1'b1;
      end else if (tx_load_tail) begin
        brk_tail_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || tx_tick) begin
      tx_div_r <= 20'h00000;
    end else begin
      tx_div_r <= tx_div_r + 20'h00001;
    end
  end

  // Frames shift out LSB first; a one refills from the top so the line
  // stays high if the count ever runs past the stop bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= 11'h7ff;
      tx_left_r  <= 4'h0;
      tx_sub_r   <= 4'h0;
    end else if (tx_load) begin
      tx_state_r <= TX_FRAME;
      tx_sub_r   <= 4'h0;
      if (tx_load_data) begin
        tx_left_r  <= frame_len;
        tx_shift_r <= word_len ? {1'b1, tx_ninth_bit, buf_r, 1'b0}
                               : {2'b11, buf_r, 1'b0};
      end else if (tx_load_break) begin
        tx_left_r  <= frame_len;
        tx_shift_r <= 11'h000;
      end else if (tx_load_tail) begin
        tx_left_r  <= 4'h1;
        tx_shift_r <= 11'h7ff;
      end else begin
        tx_left_r  <= frame_len;
        tx_shift_r <= 11'h7ff;
      end
    end else if (tx_decide) begin
      tx_state_r <= TX_IDLE;
      tx_sub_r   <= 4'h0;
    end else if (tx_state_r == TX_FRAME && tx_tick) begin
      tx_sub_r <= tx_sub_r + 4'h1;
      if (tx_bit_end) begin
        tx_shift_r <= {1'b1, tx_shift_r[10:1]};
        tx_left_r  <= tx_left_r - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o      <= 1'b1;
      tx_oe_n_o <= 1'b1;
      irq_o     <= 1'b0;
    end else begin
      tx_o      <= (tx_state_r == TX_FRAME) ? tx_shift_r[0] : 1'b1;
      tx_oe_n_o <= ~(tx_enable | rx_enable);
      irq_o     <= ~global_mask_i &
                   ((tx_buffer_empty_r & ctrl_two_r[C2_EMPTY_IE]) |
                    (tx_complete_r & ctrl_two_r[C2_DONE_IE]));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_tick) begin
      rx_div_r <= 20'h00000;
    end else begin
      rx_div_r <= rx_div_r + 20'h00001;
    end
  end

  wire logic rx_sample = (rx_state_r == RX_DATA) & rx_tick & (rx_sub_r == SUB_LAST);
  wire logic rx_stop   = rx_sample & (rx_left_r == 4'h1);
  wire logic rx_zero   = word_len ? (rx_shift_r == 9'h000) : (rx_shift_r[8:1] == 8'h00);

  // The start bit is confirmed at mid-bit; later samples fall on bit centres.
  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_enable) begin
      rx_state_r <= RX_IDLE;
      rx_sub_r   <= 4'h0;
      rx_left_r  <= 4'h0;
      rx_shift_r <= 9'h000;
    end else begin
      case (rx_state_r)
        RX_IDLE: begin
          rx_sub_r <= 4'h0;
          if (!serial_rx_in_i) begin
            rx_state_r <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (rx_sub_r == SUB_MID) begin
              rx_sub_r   <= 4'h0;
              rx_left_r  <= word_len ? RX_BITS_9 : RX_BITS_8;
              rx_state_r <= serial_rx_in_i ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_sub_r <= rx_sub_r + 4'h1;
          end
          if (rx_stop) begin
            rx_state_r <= RX_IDLE;
          end else if (rx_sample) begin
            rx_shift_r <= {serial_rx_in_i, rx_shift_r[8:1]};
            rx_left_r  <= rx_left_r - 4'h1;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_r      <= 8'h00;
      rx_ninth_bit_r <= 1'b0;
      rx_full_r      <= 1'b0;
      rx_break_r     <= 1'b0;
    end else begin
      if (rx_stop) begin
        rx_data_r <= word_len ? rx_shift_r[7:0] : rx_shift_r[8:1];
        if (word_len) begin
          rx_ninth_bit_r <= rx_shift_r[8];
        end
        rx_full_r <= 1'b1;
      end else if (rd_clear) begin
        rx_full_r <= 1'b0;
      end
      if (rx_stop && rx_zero && !serial_rx_in_i) begin
        rx_break_r <= 1'b1;
      end else if (rd_clear) begin
        rx_break_r <= 1'b0;
      end
    end
  end

  a_idle_line_high: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_state_r == TX_IDLE |=> tx_o) else $error("line not high while idle");
  a_pin_released: assert property (@(posedge clk_i) disable iff (rst_i)
    !(tx_enable || rx_enable) |=> tx_oe_n_o) else $error("pin not released");
  a_start_bit_low: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_load_data |-> ##2 !tx_o) else $error("start bit not low");
  a_empty_on_load: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_load_data && !wr_data |=> tx_buffer_empty_r && !buf_full_r) else $error("empty flag not set");
  a_empty_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_clear && !tx_load_data |=> !tx_buffer_empty_r) else $error("empty flag kept");
  a_done_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_clear && !tx_frame_end |=> !tx_complete_r) else $error("complete flag kept");
  a_done_on_end: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_frame_end && !tx_load |=> tx_complete_r ##0 tx_state_r == TX_IDLE)
    else $error("complete flag missing");
  a_irq_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    global_mask_i |=> !irq_o) else $error("interrupt leaked through mask");
  a_break_low: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_load_break |-> ##2 !tx_o [*8]) else $error("break not low");
  a_ninth_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_load_data && word_len |=> tx_shift_r[9] == $past(tx_ninth_bit))
    else $error("ninth bit wrong");
  a_enable_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    te_rise |=> idle_pend_r && !buf_full_r || $past(wr_data)) else $error("idle not armed");

  c_data_frame: cover property (@(posedge clk_i) disable iff (rst_i)
    tx_load_data ##[1:300] tx_frame_end);
  c_break_tail: cover property (@(posedge clk_i) disable iff (rst_i)
    tx_load_break ##[1:300] tx_load_tail);
  c_idle_frame: cover property (@(posedge clk_i) disable iff (rst_i) tx_load_idle);
  c_rx_frame:   cover property (@(posedge clk_i) disable iff (rst_i) rx_stop && word_len);

endmodule

`default_nettype wire

/* File: design/serial_tx_pkg.sv */
// Purpose: Shared constants and types for the asynchronous serial frame block.
// Assumes: Classic Wishbone slave with 32-bit data, registers in the low byte lane.
// Notes:   Register offsets and bit positions are local choices of this block.

package serial_tx_pkg;

  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_DATA     = 8'h04;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h08;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h0c;
  localparam logic [7:0] OFS_BAUD     = 8'h10;
  localparam logic [7:0] OFS_TX_FINE  = 8'h14;
  localparam logic [7:0] OFS_RX_FINE  = 8'h18;

  localparam int ST_TX_EMPTY   = 7;
  localparam int ST_TX_DONE    = 6;
  localparam int ST_RX_FULL    = 5;
  localparam int ST_RX_BREAK   = 4;
  localparam int C1_RX_NINTH   = 7;
  localparam int C1_TX_NINTH   = 6;
  localparam int C1_WORD_LEN   = 4;
  localparam int C2_EMPTY_IE   = 7;
  localparam int C2_DONE_IE    = 6;
  localparam int C2_TX_EN      = 3;
  localparam int C2_RX_EN      = 2;
  localparam int C2_BREAK      = 0;

  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] BAUD_RST     = 8'h00;
  localparam logic [7:0] FINE_RST     = 8'h00;

  localparam logic [3:0] SUB_LAST    = 4'hf;
  localparam logic [3:0] SUB_MID     = 4'h7;
  localparam logic [3:0] FRAME_LEN_8 = 4'ha;
  localparam logic [3:0] FRAME_LEN_9 = 4'hb;
  localparam logic [3:0] RX_BITS_8   = 4'h9;
  localparam logic [3:0] RX_BITS_9   = 4'ha;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_FRAME = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } rx_state_t;

  // Ticks of the system clock per oversampling tick; the sixteen-fold step is
  // made by the bit timers so the generator only covers the remaining factors.
  function automatic logic [19:0] baud_div(input logic [1:0] pr_sel,
                                           input logic [2:0] pow_sel,
                                           input logic [7:0] fine);
    logic [19:0] pr;
    logic [19:0] f;
    case (pr_sel)
      2'h0:    pr = 20'h00001;
      2'h1:    pr = 20'h00003;
      2'h2:    pr = 20'h00004;
      default: pr = 20'h0000d;
    endcase
    f = (fine == 8'h00) ? 20'h00001 : {12'h000, fine};
    baud_div = 20'((pr << pow_sel) * f);
  endfunction

endpackage

/* File: tb/serial_far_end.sv */
// Purpose: Far-end serial equipment that decodes the transmit line and sends receive frames.
// Assumes: Bit times are given in system clock cycles; a released line reads high.
// Notes:   Frames are {stop, ninth, data}; the ninth bit is zero in 8-bit mode.
`timescale 1ns/10ps
`default_nettype none

module serial_far_end (
  input  wire logic        clk_i,
  input  wire logic        line_i,
  input  wire logic        nine_i,
  input  wire logic [15:0] tx_bit_i,
  input  wire logic [15:0] rx_bit_i,
  input  wire logic        send_i,
  input  wire logic [9:0]  send_frame_i,
  output logic             rx_o,
  output logic             got_o,
  output logic [9:0]       got_frame_o
);
  logic [9:0]  f;
  logic [10:0] s;
  int          i;
  int          j;

  initial begin
    rx_o = 1'b1;
    got_o = 1'b0;
    got_frame_o = 10'h000;
  end

  // Sampling mid-bit keeps a cycle or two of launch skew harmless.
  always begin
    @(negedge line_i);
    repeat (tx_bit_i / 2) @(posedge clk_i);
    if (line_i === 1'b0) begin
      f = 10'h000;
      for (i = 0; i < (nine_i ? 10 : 9); i++) begin
        repeat (tx_bit_i) @(posedge clk_i);
        f[i] = line_i;
      end
      if (!nine_i) f = {f[8], 1'b0, f[7:0]};
      got_frame_o <= f;
      got_o <= 1'b1;
      @(posedge clk_i);
      got_o <= 1'b0;
    end
  end

  // One whole frame per request, LSB first, then the line idles high.
  always @(posedge clk_i) begin
    if (send_i === 1'b1) begin
      s = nine_i ? {1'b1, send_frame_i} : {2'b11, send_frame_i[9], send_frame_i[7:0]};
      rx_o <= 1'b0;
      for (j = 0; j < 11; j++) begin
        repeat (rx_bit_i) @(posedge clk_i);
        rx_o <= s[j];
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/test_async_serial_transmitter_frame.sv */
// Purpose: Self-checking bench for the serial transmitter block over Wishbone.
// Assumes: Divider settings give whole bit times of 16 * D system clocks.
// Notes:   Reads and received frames are checked from queues by a watcher process.
`timescale 1ns/10ps
`default_nettype none

module test_async_serial_transmitter_frame;
  import serial_tx_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        mask = 1'b1, nine = 1'b0, send = 1'b0, brk = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [15:0] txb = 16'h0010, rxb = 16'h0010, rnd = 16'h9d29;
  logic [9:0]  sframe = 10'h000, gframe;
  logic        ack, tx, oe_n, irq, rxl, got, line;
  logic [31:0] rd_q[$], rm_q[$];
  logic [9:0]  fr_q[$];
  int          bad_count = 0, compares = 0, n, brk_seen = 0;

  // The released pin is pulled high outside the block.
  assign line = oe_n ? 1'b1 : tx;
  always #50 clk_i = ~clk_i;

  async_serial_transmitter_frame async_serial_transmitter_frame_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .global_mask_i(mask), .serial_rx_in_i(rxl), .tx_o(tx), .tx_oe_n_o(oe_n), .irq_o(irq));

  serial_far_end serial_far_end_i (
    .clk_i(clk_i), .line_i(line), .nine_i(nine), .tx_bit_i(txb), .rx_bit_i(rxb),
    .send_i(send), .send_frame_i(sframe), .rx_o(rxl), .got_o(got), .got_frame_o(gframe));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cycles(input int c);
    repeat (c) @(negedge clk_i);
  endtask

  // Classic cycle: hold everything until ack is seen, release on the next rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    for (k = 0; k < 20 && ack !== 1'b1; k++) @(negedge clk_i);
    if (ack !== 1'b1) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rd_q.push_back({24'h0, e});
    rm_q.push_back({24'hffffff, m});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic send_byte(input logic [8:0] d);
    rd(OFS_STATUS, 8'h00, 8'h00);
    wr(OFS_DATA, d[7:0]);
    fr_q.push_back({1'b1, d});
  endtask

  task automatic drain;
    int k;
    for (k = 0; k < 9000 && fr_q.size() > 0; k++) @(negedge clk_i);
    if (fr_q.size() > 0) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
    cycles(txb);
  endtask

  task automatic far(input logic [9:0] f);
    @(posedge clk_i);
    sframe <= f;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    cycles(12 * rxb + 30);
  endtask

  always @(negedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) begin
      chk(rdat & rm_q[0], rd_q[0] & rm_q[0]);
      void'(rd_q.pop_front());
      void'(rm_q.pop_front());
    end
    if (got === 1'b1) begin
      if (brk) begin
        brk_seen++;
        chk(gframe, 10'h000);
      end else if (fr_q.size() == 0) begin
        chk(gframe, 32'hffffffff);
      end else begin
        chk(gframe, fr_q.pop_front());
      end
    end
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    chk(32'h0, 32'h1);
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_STATUS, 8'hc0, 8'hf0);
    rd(OFS_CTRL_ONE, 8'h00, 8'hff);
    rd(OFS_CTRL_TWO, 8'h00, 8'hff);
    rd(8'h1c, 8'h00, 8'hff);
    chk(oe_n, 1'b1);
    wr(OFS_CTRL_TWO, 8'h0c);
    cycles(2);
    chk({oe_n, tx}, 2'b01);
    send_byte(9'h055);
    rd(OFS_STATUS, 8'h00, 8'hc0);
    for (n = 0; n < 300 && tx !== 1'b0; n++) @(negedge clk_i);
    chk(n > 140 && n < 175, 1'b1);
    rd(OFS_STATUS, 8'h80, 8'hc0);
    send_byte(9'h0a3);
    drain();
    rd(OFS_STATUS, 8'hc0, 8'hc0);
    repeat (3) begin
      rnd = lfsr(rnd);
      send_byte({1'b0, rnd[7:0]});
      cycles(2);
      rd(OFS_STATUS, 8'h80, 8'hc0);
      drain();
    end
    send_byte(9'h0f0);
    rd(OFS_STATUS, 8'h00, 8'h00);
    wr(OFS_DATA, 8'h0f);
    wr(OFS_CTRL_TWO, 8'h00);
    wr(OFS_CTRL_TWO, 8'h0c);
    send_byte(9'h011);
    drain();
    wr(OFS_CTRL_TWO, 8'h8c);
    cycles(2);
    chk(irq, 1'b0);
    @(posedge clk_i);
    mask <= 1'b0;
    cycles(2);
    chk(irq, 1'b1);
    wr(OFS_CTRL_TWO, 8'h4c);
    cycles(2);
    chk(irq, 1'b1);
    wr(OFS_CTRL_TWO, 8'h0c);
    cycles(2);
    chk(irq, 1'b0);
    wr(OFS_CTRL_ONE, 8'h50);
    nine <= 1'b1;
    send_byte(9'h13c);
    drain();
    wr(OFS_CTRL_ONE, 8'h10);
    send_byte(9'h0c3);
    drain();
    far({1'b1, 9'h1a5});
    rd(OFS_STATUS, 8'h20, 8'h20);
    rd(OFS_CTRL_ONE, 8'h80, 8'h80);
    rd(OFS_DATA, 8'ha5, 8'hff);
    wr(OFS_CTRL_ONE, 8'h00);
    nine <= 1'b0;
    far({1'b0, 9'h000});
    rd(OFS_STATUS, 8'h10, 8'h10);
    rd(OFS_DATA, 8'h00, 8'h00);
    brk = 1'b1;
    wr(OFS_CTRL_TWO, 8'h0d);
    cycles(400);
    wr(OFS_CTRL_TWO, 8'h0c);
    for (n = 0; n < 400 && tx !== 1'b1; n++) @(negedge clk_i);
    for (n = 0; n < 16 && tx === 1'b1; n++) @(negedge clk_i);
    chk(n, 16);
    brk = 1'b0;
    chk(brk_seen > 0, 1'b1);
    wr(OFS_CTRL_TWO, 8'h00);
    cycles(2);
    chk(oe_n, 1'b1);
    wr(OFS_BAUD, 8'h48);
    wr(OFS_TX_FINE, 8'h02);
    txb <= 16'd192;
    rxb <= 16'd48;
    wr(OFS_CTRL_TWO, 8'h0c);
    send_byte(9'h096);
    drain();
    far({1'b1, 9'h069});
    rd(OFS_STATUS, 8'h20, 8'h20);
    rd(OFS_DATA, 8'h69, 8'hff);
    end_of_test();
  end
endmodule
`default_nettype wire
